// ==== core/wake_event_indicator.sv ====
// wake event indicator: wake cause status, wake output pin, ready flag, apb slave
// Notes on behaviour
// - cause field: 00 none, 01 energy, 10 frame or magic, 11 multiple
// - cause bits clear only on a written one; zero leaves them
// - clears ignored unless in normal power state with ready set
// - cause bit stays set while any source feeding it remains active
// - pulse mode drives output active for 50 ms per event
// - static mode holds output active until deactivated
// - clearing cause bits or the matching enable deasserts the output
// - polarity one gives active high, zero active low
// - open-drain ignores polarity and is always active low
// - output driven only while output enable is set
// - internal wake interrupt ignores the output enable
// - read-only ready flag set once settled after power-up or wake
// - control register reads answer in every power state
// - power field: normal, frame detect 01, energy detect 10, reserved
// - buffer type clear gives open-drain, set gives push-pull
// - enabled events raise the internal interrupt regardless of pin enable
// - write of any value to byte test wakes from reduced power
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module wake_event_indicator #(
  parameter int settle_cycles = wake_pkg::settle_cycles_default,
  parameter int pulse_len = wake_pkg::pulse_cycles
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire wake_pkg::apb_req_s apb_req,
  output wake_pkg::apb_rsp_s apb_rsp,
  // event sources, asynchronous levels: bit 0 energy, bit 1 frame or magic
  input wire logic [1:0] event_src,
  // wake pin
  output wake_pkg::pin_s wake_event_out,
  // internal interrupt and power state
  output logic wake_interrupt,
  output logic [1:0] power_state
);
  import wake_pkg::*;

  typedef enum {st_settle, st_ready, st_sleep} dev_state_e;
  typedef enum {pl_idle, pl_run} pulse_state_e;

  dev_state_e dev_state;
  pulse_state_e pulse_state;
  logic [1:0] src;
  logic [1:0] src_q;
  logic [1:0] wake_cause;
  logic [1:0] power_state_field;
  logic wake_out_pulse_sel;
  logic wake_out_polarity;
  logic wake_out_enable;
  logic wake_out_buffer_type;
  logic lan_wake_enable;
  logic energy_wake_enable;
  logic ready;
  logic [31:0] settle_cnt;
  logic [31:0] pulse_cnt;
  logic static_active;
  logic pin_active;
  logic [1:0] enabled_rise;
  logic new_event;
  logic wr_en;
  logic rd_en;
  logic [1:0] clear_req;
  logic [31:0] ctrl_word;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction : hit

  wake_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(event_src),
    .stable(src)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 2'h0;
    end else begin
      src_q <= src;
    end
  end

  // index 0 energy, index 1 frame; only enabled sources count as wake events
  assign enabled_rise = src & ~src_q & {lan_wake_enable, energy_wake_enable};
  assign new_event = |enabled_rise;

  // slave answers in the access cycle with no wait states
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite;

  // clear is allowed only when normal and ready
  assign clear_req = (wr_en && hit(apb_req.paddr, power_mgmt_control_addr)
                      && ready && power_state_field == power_normal) ?
                     apb_req.pwdata[cause_lo +: 2] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cause <= cause_none;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // set wins over clear; an active source blocks the clear
        if (enabled_rise[i]) begin
          wake_cause[i] <= 1'b1;
        end else if (clear_req[i] && !src[i]) begin
          wake_cause[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_out_pulse_sel <= 1'b0;
      wake_out_polarity <= 1'b0;
      wake_out_enable <= 1'b0;
      wake_out_buffer_type <= 1'b0;
      lan_wake_enable <= 1'b0;
      energy_wake_enable <= 1'b0;
    end else if (wr_en && hit(apb_req.paddr, power_mgmt_control_addr) && ready) begin
      wake_out_pulse_sel <= apb_req.pwdata[pulse_sel_bit];
      wake_out_polarity <= apb_req.pwdata[polarity_bit];
      wake_out_enable <= apb_req.pwdata[out_enable_bit];
      wake_out_buffer_type <= apb_req.pwdata[buffer_type_bit];
      lan_wake_enable <= apb_req.pwdata[lan_en_bit];
      energy_wake_enable <= apb_req.pwdata[energy_en_bit];
    end
  end

  // power field and ready flag; a reserved code is held like a reduced state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_state <= st_settle;
      power_state_field <= power_normal;
      settle_cnt <= 32'h0;
    end else begin
      case (dev_state)
        st_settle: begin
          if (settle_cnt >= 32'(settle_cycles - 1)) begin
            dev_state <= st_ready;
            settle_cnt <= 32'h0;
          end else begin
            settle_cnt <= settle_cnt + 32'h1;
          end
        end
        st_ready: begin
          if (wr_en && hit(apb_req.paddr, power_mgmt_control_addr)
              && apb_req.pwdata[power_lo +: 2] != power_normal) begin
            power_state_field <= apb_req.pwdata[power_lo +: 2];
            dev_state <= st_sleep;
          end
        end
        st_sleep: begin
          // a wake event or a byte test write brings the device back
          if ((wr_en && hit(apb_req.paddr, byte_test_addr)) || new_event) begin
            power_state_field <= power_normal;
            dev_state <= st_settle;
          end
        end
        default: begin
          dev_state <= st_settle;
        end
      endcase
    end
  end

  assign ready = (dev_state == st_ready);
  assign power_state = power_state_field;

  // pulse timer on pclk; a new event during a pulse does not stretch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_state <= pl_idle;
      pulse_cnt <= 32'h0;
    end else begin
      case (pulse_state)
        pl_idle: begin
          if (new_event && wake_out_pulse_sel) begin
            pulse_state <= pl_run;
            pulse_cnt <= 32'h0;
          end
        end
        pl_run: begin
          if (wake_cause == cause_none) begin
            pulse_state <= pl_idle;
          end else if (pulse_cnt >= 32'(pulse_len - 1)) begin
            pulse_state <= pl_idle;
          end else begin
            pulse_cnt <= pulse_cnt + 32'h1;
          end
        end
        default: begin
          pulse_state <= pl_idle;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      static_active <= 1'b0;
    end else if (new_event && !wake_out_pulse_sel) begin
      static_active <= 1'b1;
    end else if (wake_cause == cause_none || !(lan_wake_enable || energy_wake_enable)) begin
      static_active <= 1'b0;
    end
  end

  // the pin drops as soon as its causing enable is cleared
  assign pin_active = ((pulse_state == pl_run) || static_active)
                      && |(wake_cause & {lan_wake_enable, energy_wake_enable})
                      && wake_out_enable;

  // open-drain: drive low when active, release otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event_out <= '{out: 1'b0, out_oe_n: 1'b1};
    end else if (!wake_out_buffer_type) begin
      wake_event_out <= '{out: 1'b0, out_oe_n: !pin_active};
    end else if (!wake_out_enable) begin
      wake_event_out <= '{out: 1'b0, out_oe_n: 1'b1};
    end else begin
      wake_event_out <= '{out: pin_active ~^ wake_out_polarity, out_oe_n: 1'b0};
    end
  end

  // interrupt level follows the enabled cause bits, not the pin enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_interrupt <= 1'b0;
    end else begin
      wake_interrupt <= |(wake_cause & {lan_wake_enable, energy_wake_enable});
    end
  end

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[power_lo +: 2] = power_state_field;
    ctrl_word[lan_en_bit] = lan_wake_enable;
    ctrl_word[energy_en_bit] = energy_wake_enable;
    ctrl_word[buffer_type_bit] = wake_out_buffer_type;
    ctrl_word[cause_lo +: 2] = wake_cause;
    ctrl_word[pulse_sel_bit] = wake_out_pulse_sel;
    ctrl_word[polarity_bit] = wake_out_polarity;
    ctrl_word[out_enable_bit] = wake_out_enable;
    ctrl_word[ready_bit] = ready;
  end

  // read data registered at setup; control register readable in any state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp.prdata <= 32'h0;
    end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      if (hit(apb_req.paddr, power_mgmt_control_addr)) begin
        apb_rsp.prdata <= ctrl_word;
      end else if (hit(apb_req.paddr, wake_status_addr)) begin
        apb_rsp.prdata <= {30'h0, src};
      end else begin
        apb_rsp.prdata <= 32'h0;
      end
    end
  end

  // unmapped addresses, and other addresses while not ready, answer with an error
  always_comb begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = 1'b0;
    if (apb_req.psel && apb_req.penable) begin
      if (hit(apb_req.paddr, power_mgmt_control_addr)
          || hit(apb_req.paddr, hardware_config_addr)
          || (hit(apb_req.paddr, byte_test_addr) && apb_req.pwrite)) begin
        apb_rsp.pslverr = 1'b0;
      end else if (!ready) begin
        apb_rsp.pslverr = 1'b1;
      end else if (!hit(apb_req.paddr, wake_status_addr)) begin
        apb_rsp.pslverr = 1'b1;
      end
    end
  end

  // pulse never outlasts its programmed length
  a_pulse_length_bound: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_state == pl_run |-> pulse_cnt < 32'(pulse_len))
    else $error("pulse counter ran past its length");

  sequence s_clear_write;
    wr_en && hit(apb_req.paddr, power_mgmt_control_addr) && apb_req.pwdata[cause_lo];
  endsequence

  a_clear_needs_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (s_clear_write and !ready and wake_cause[0] and !enabled_rise[0]) |=> wake_cause[0])
    else $error("cause bit cleared while not ready");

  a_source_holds_cause: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_cause[0] && src[0]) |=> wake_cause[0])
    else $error("cause bit cleared with source active");

  a_zero_write_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && !apb_req.pwdata[cause_lo + 1] && wake_cause[1]) |=> wake_cause[1])
    else $error("cause bit cleared by a zero");

  a_multi_events: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_cause != cause_none && (wake_cause | enabled_rise) == cause_multi
     && clear_req == 2'h0) |=> wake_cause == cause_multi)
    else $error("second event did not give multiple code");

  a_enable_gates_pin: assert property (@(posedge pclk) disable iff (!presetn)
    !wake_out_enable |=> wake_event_out.out_oe_n)
    else $error("pin driven while disabled");

  a_polarity_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_out_buffer_type && wake_out_enable) |=>
    ((wake_event_out.out == $past(wake_out_polarity)) == $past(pin_active)))
    else $error("push-pull pin level ignores polarity");

  a_push_pull_drives: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_out_buffer_type && wake_out_enable) |=> !wake_event_out.out_oe_n)
    else $error("push-pull pin not driven");

  a_static_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (new_event && !wake_out_pulse_sel) |=> static_active)
    else $error("static indication not raised");

  a_open_drain_low: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(wake_out_buffer_type) |-> !wake_event_out.out)
    else $error("open drain pin not low");

  a_interrupt_ignores_en: assert property (@(posedge pclk) disable iff (!presetn)
    (|(wake_cause & {lan_wake_enable, energy_wake_enable})
     && !wake_out_enable) |=> wake_interrupt)
    else $error("interrupt gated by pin enable");

  a_ready_after_settle: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ready) |-> $past(settle_cnt) == 32'(settle_cycles - 1))
    else $error("ready before settling");

  a_pulse_starts: assert property (@(posedge pclk) disable iff (!presetn)
    (new_event && wake_out_pulse_sel && pulse_state == pl_idle) |=> pulse_state == pl_run)
    else $error("pulse did not start");
endmodule : wake_event_indicator

// ==== core/wake_pkg.sv ====
// package with register map, field layout and timing constants for the wake event indicator
package wake_pkg;
  localparam logic [7:0] power_mgmt_control_addr = 8'h84;
  localparam logic [7:0] byte_test_addr = 8'h64;
  localparam logic [7:0] hardware_config_addr = 8'h74;
  localparam logic [7:0] wake_status_addr = 8'hF0;
  localparam int ready_bit = 0;
  localparam int out_enable_bit = 1;
  localparam int polarity_bit = 2;
  localparam int pulse_sel_bit = 3;
  localparam int cause_lo = 4;
  localparam int buffer_type_bit = 6;
  localparam int energy_en_bit = 8;
  localparam int lan_en_bit = 9;
  localparam int power_lo = 12;
  localparam logic [1:0] power_normal = 2'h0;
  localparam logic [1:0] power_frame = 2'h1;
  localparam logic [1:0] power_energy = 2'h2;
  localparam logic [1:0] cause_none = 2'h0;
  localparam logic [1:0] cause_energy = 2'h1;
  localparam logic [1:0] cause_frame = 2'h2;
  localparam logic [1:0] cause_multi = 2'h3;
  localparam int clk_hz = 25000000;
  localparam int pulse_ms = 50;
  localparam int pulse_cycles = clk_hz / 1000 * pulse_ms;
  localparam int settle_cycles_default = 64;
  localparam int sync_depth = 3;
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;
  typedef struct packed {
    logic out;
    logic out_oe_n;
  } pin_s;
endpackage : wake_pkg

// ==== core/wake_sync.sv ====
// three-stage synchroniser for the asynchronous event inputs
`timescale 1ns/1ps
module wake_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [1:0] async_in,
  output logic [1:0] stable
);
  import wake_pkg::*;
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 2'h0;
      s2 <= 2'h0;
      s3 <= 2'h0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // a change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (s2[i] == s3[i]) begin
          stable[i] <= s3[i];
        end
      end
    end
  end
endmodule : wake_sync

// ==== dv/wake_host.sv ====
// host model: apb master for the wake event indicator registers
`timescale 1ns/1ps
module wake_host (
  // clock
  input wire logic pclk,
  // apb master side
  output wake_pkg::apb_req_s apb_req,
  input wire wake_pkg::apb_rsp_s apb_rsp
);
  import wake_pkg::*;
  logic ready_seen;
  initial begin
    apb_req = '0;
    ready_seen = 1'b0;
  end
  task automatic xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    rdata = '0;
    err = 1'b1;
    // before ready only the control and config reads and the byte test wake write go out
    if (ready_seen || addr == power_mgmt_control_addr && !wr ||
        addr == hardware_config_addr && !wr || addr == byte_test_addr && wr) begin
      @(posedge pclk);
      apb_req <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wdata};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
      rdata = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      if (addr == power_mgmt_control_addr && !wr) ready_seen = rdata[ready_bit];
      // entering sleep drops ready at once, so stop touching other places
      if (addr == power_mgmt_control_addr && wr && wdata[13:12] != 2'h0) ready_seen = 1'b0;
    end
  endtask : xfer
endmodule : wake_host

// ==== dv/wake_event_indicator_tb.sv ====
// self-checking bench for the wake event indicator
`timescale 1ns/1ps
module wake_event_indicator_tb;
  import wake_pkg::*;
  localparam int pulse_n = 20;
  logic pclk;
  logic presetn;
  apb_req_s apb_req;
  apb_rsp_s apb_rsp;
  logic [1:0] event_src;
  pin_s wake_event_out;
  logic wake_interrupt;
  logic [1:0] power_state;
  int n_fail;
  int checks_done;
  int cycles;
  logic [31:0] rd;
  logic err;

  wake_event_indicator #(.settle_cycles(16), .pulse_len(pulse_n)) i_wake_event_indicator (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .event_src(event_src), .wake_event_out(wake_event_out),
    .wake_interrupt(wake_interrupt), .power_state(power_state));
  wake_host i_wake_host (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // timeout well above the few hundred cycles the scenarios need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wake_host.xfer(a, 1'b1, d, rd, err);
  endtask : wr
  task automatic rd_ctrl(input logic [31:0] exp);
    i_wake_host.xfer(power_mgmt_control_addr, 1'b0, '0, rd, err);
    chk_word(rd, exp);
  endtask : rd_ctrl
  task automatic wait_ready;
    int i;
    rd = '0;
    for (i = 0; i < 60 && rd[ready_bit] !== 1'b1; i++)
      i_wake_host.xfer(power_mgmt_control_addr, 1'b0, '0, rd, err);
    chk_bit(rd[ready_bit], 1'b1);
  endtask : wait_ready

  task automatic t_boot;
    rd_ctrl(32'h0000_0000);
    i_wake_host.xfer(hardware_config_addr, 1'b0, '0, rd, err);
    chk_bit(err, 1'b0);
    wait_ready();
    rd_ctrl(32'h0000_0001);
    i_wake_host.xfer(8'h10, 1'b0, '0, rd, err);
    chk_bit(err, 1'b1);
    chk_word(rd, 32'h0000_0000);
  endtask : t_boot

  task automatic t_static;
    wr(power_mgmt_control_addr, 32'h0000_0146);
    event_src <= 2'h1;
    cyc(10);
    rd_ctrl(32'h0000_0157);
    chk_bit(wake_event_out.out, 1'b1);
    chk_bit(wake_interrupt, 1'b1);
    wr(power_mgmt_control_addr, 32'h0000_0156);
    rd_ctrl(32'h0000_0157);
    event_src <= 2'h0;
    cyc(10);
    wr(power_mgmt_control_addr, 32'h0000_0166);
    rd_ctrl(32'h0000_0157);
    cyc(40);
    chk_bit(wake_event_out.out, 1'b1);
    wr(power_mgmt_control_addr, 32'h0000_0156);
    rd_ctrl(32'h0000_0147);
    cyc(3);
    chk_bit(wake_event_out.out, 1'b0);
  endtask : t_static

  task automatic t_pulse;
    wr(power_mgmt_control_addr, 32'h0000_034A);
    event_src <= 2'h2;
    cyc(8);
    chk_bit(wake_event_out.out, 1'b0);
    event_src <= 2'h3;
    cyc(8);
    rd_ctrl(32'h0000_037B);
    cyc(pulse_n);
    chk_bit(wake_event_out.out, 1'b1);
    event_src <= 2'h0;
    cyc(10);
    wr(power_mgmt_control_addr, 32'h0000_037A);
    rd_ctrl(32'h0000_034B);
  endtask : t_pulse

  task automatic t_open_drain;
    wr(power_mgmt_control_addr, 32'h0000_0106);
    event_src <= 2'h1;
    cyc(10);
    chk_bit(wake_event_out.out, 1'b0);
    chk_bit(wake_event_out.out_oe_n, 1'b0);
    wr(power_mgmt_control_addr, 32'h0000_0104);
    cyc(3);
    chk_bit(wake_event_out.out_oe_n, 1'b1);
    chk_bit(wake_interrupt, 1'b1);
    wr(power_mgmt_control_addr, 32'h0000_0004);
    cyc(3);
    chk_bit(wake_interrupt, 1'b0);
    event_src <= 2'h0;
    cyc(10);
    wr(power_mgmt_control_addr, 32'h0000_0014);
    rd_ctrl(32'h0000_0005);
  endtask : t_open_drain

  task automatic t_sleep;
    logic [1:0] modes [2];
    modes = '{power_frame, power_energy};
    foreach (modes[i]) begin
      wr(power_mgmt_control_addr, {18'h0, modes[i], 12'h0});
      cyc(2);
      chk_word({30'h0, power_state}, {30'h0, modes[i]});
      rd_ctrl({18'h0, modes[i], 12'h0});
      wr(byte_test_addr, 32'hA5A5_5A5A);
      wait_ready();
      rd_ctrl(32'h0000_0001);
    end
  endtask : t_sleep

  // an enabled event, not a byte test write, brings the device back here
  task automatic t_event_wake;
    wr(power_mgmt_control_addr, {18'h0, power_energy, 12'h100});
    cyc(2);
    chk_word({30'h0, power_state}, {30'h0, power_energy});
    event_src <= 2'h1;
    wait_ready();
    rd_ctrl(32'h0000_0111);
    chk_bit(wake_interrupt, 1'b1);
    event_src <= 2'h0;
    cyc(10);
    wr(power_mgmt_control_addr, 32'h0000_0110);
    rd_ctrl(32'h0000_0101);
  endtask : t_event_wake

  initial begin
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    rd = '0;
    event_src = 2'h0;
    presetn = 1'b0;
    cyc(2);
    presetn <= 1'b1;
    t_boot();
    t_static();
    t_pulse();
    t_open_drain();
    t_sleep();
    t_event_wake();
    give_verdict();
  end
endmodule : wake_event_indicator_tb
